// ---- pkg/aocr_pkg.sv ----
// output configuration register bank: offsets, fields, reset values, types
// assumes a 32-bit apb slave with 16-bit registers in the low half of each word
package aocr_pkg;

  // ====================================================================
  // register indices and address width
  localparam logic [7:0] AOCR_IDX_LANE = 8'h01;
  localparam logic [7:0] AOCR_IDX_PAT = 8'h02;
  localparam logic [7:0] AOCR_IDX_SER = 8'h03;
  localparam logic [7:0] AOCR_IDX_STAT = 8'h04;
  localparam int AOCR_ADDR_W = 12;

  // ====================================================================
  // field positions
  localparam int AOCR_LANE_MERGE_BIT = 14;
  localparam int AOCR_SER_OFF_BIT = 5;
  localparam int AOCR_ONE4_BIT = 4;
  localparam int AOCR_ONE2_BIT = 2;
  localparam int AOCR_PDN_BIT = 0;
  localparam int AOCR_FRM_PAT_LSB = 13;
  localparam int AOCR_LOWLAT_BIT = 12;
  localparam int AOCR_AVG_BIT = 11;
  localparam int AOCR_FRM_RND_BIT = 10;
  localparam int AOCR_DAT_PAT_LSB = 7;
  localparam int AOCR_GBL_RND_BIT = 6;
  localparam int AOCR_DLY_LO_LSB = 0;
  localparam int AOCR_SER_RATE_LSB = 13;
  localparam int AOCR_GAIN_BIT = 12;
  localparam int AOCR_DLY_HI_LSB = 9;
  localparam int AOCR_DOFS_BIT = 8;

  // ====================================================================
  // reset values, lane read mask and serial writable mask
  localparam logic [15:0] AOCR_LANE_RST = 16'h0014;
  localparam logic [15:0] AOCR_PAT_RST = 16'h0000;
  localparam logic [15:0] AOCR_SER_RST = 16'h0000;
  localparam logic [15:0] AOCR_LANE_RD_MASK = 16'h4021;
  localparam logic [15:0] AOCR_SER_MASK = 16'hf700;

  // ====================================================================
  // pattern and rate encodings
  typedef enum logic [2:0] {
    AOCR_PAT_NORMAL = 3'h0,
    AOCR_PAT_SYNC = 3'h1,
    AOCR_PAT_ALT = 3'h2,
    AOCR_PAT_CUSTOM = 3'h3,
    AOCR_PAT_ONES = 3'h4,
    AOCR_PAT_TOGGLE = 3'h5,
    AOCR_PAT_ZEROS = 3'h6,
    AOCR_PAT_RAMP = 3'h7
  } aocr_pat_t;

  localparam logic [2:0] AOCR_RATE_12X = 3'h0;
  localparam logic [2:0] AOCR_RATE_14X = 3'h1;
  localparam logic [2:0] AOCR_RATE_16X = 3'h4;
  localparam logic [4:0] AOCR_BITS_12 = 5'h0c;
  localparam logic [4:0] AOCR_BITS_14 = 5'h0e;
  localparam logic [4:0] AOCR_BITS_16 = 5'h10;

  // ====================================================================
  // decoded settings handed to the datapath
  typedef struct packed {
    logic dual_lane_merge;
    logic serial_output_off;
    logic full_power_down;
    logic low_latency;
    logic channel_pair_average;
    logic frame_line_random_sel;
    logic global_random_sel;
    aocr_pat_t data_line_pattern;
    aocr_pat_t frame_line_pattern;
    logic [7:0] offset_fix_start_delay;
    logic [2:0] serialization_factor;
    logic [4:0] bits_per_sample;
    logic rate_code_valid;
    logic digital_gain_on;
    logic digital_offset_on;
  } aocr_cfg_t;

  typedef struct packed {
    logic [AOCR_ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } aocr_apb_req_t;

endpackage

// ---- design/aocr_sync.sv ----
// two-flop synchroniser for a single level from outside the clock domain
// assumes the level is held long enough to be seen at clk
`timescale 1ns/1ns
module aocr_sync
  import aocr_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // level
  input wire logic din,
  output logic dout
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (ce) begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule

// ---- design/aocr_trig_delay.sv ----
// counts samples after a trigger rising edge and pulses offset-fix start
// assumes sample_tick marks one converter sample, trig already synchronised
`timescale 1ns/1ns
module aocr_trig_delay
  import aocr_pkg::*;
#(
  parameter int DLY_W = 8
) (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // timing
  input wire logic sample_tick,
  input wire logic trig,
  input wire logic [DLY_W-1:0] delay,
  // result
  output logic start,
  output logic busy
);

  logic trig_q;
  logic busy_q;
  logic busy_d;
  logic start_q;
  logic start_d;
  logic [DLY_W-1:0] cnt_q;
  logic [DLY_W-1:0] cnt_d;
  wire trig_rise = trig & ~trig_q;
  wire done = busy_q & sample_tick & (cnt_q == delay);

  // a new trigger restarts the count; the delay is read live
  always_comb begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    start_d = 1'b0;
    if (trig_rise) begin
      busy_d = 1'b1;
      cnt_d = '0;
    end else if (done) begin
      busy_d = 1'b0;
      start_d = 1'b1;
    end else if (busy_q && sample_tick) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_q <= 1'b0;
      busy_q <= 1'b0;
      cnt_q <= '0;
      start_q <= 1'b0;
    end else if (ce) begin
      trig_q <= trig;
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      start_q <= start_d;
    end
  end

  assign start = start_q;
  assign busy = busy_q;

endmodule

// ---- design/aocr_regs.sv ----
// apb register bank for the converter output path configuration
// assumes apb master on clk; transmit trigger is an asynchronous pin
`timescale 1ns/1ns

module aocr_regs
  import aocr_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic [AOCR_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter timing
  input wire logic sample_tick,
  input wire logic transmit_trigger_input,
  // decoded settings
  output aocr_cfg_t cfg,
  output logic serial_lanes_on,
  output logic converter_on,
  output logic offset_fix_start
);

  // ==================================================================
  // address decode
  function automatic logic hit(input logic [AOCR_ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[AOCR_ADDR_W-1:2] == {{(AOCR_ADDR_W-10){1'b0}}, idx}) && (a[1:0] == 2'h0);
  endfunction

  wire sel_lane = hit(paddr, AOCR_IDX_LANE);
  wire sel_pat = hit(paddr, AOCR_IDX_PAT);
  wire sel_ser = hit(paddr, AOCR_IDX_SER);
  wire sel_stat = hit(paddr, AOCR_IDX_STAT);
  wire mapped = sel_lane | sel_pat | sel_ser | sel_stat;
  wire access = psel & penable;
  wire wr = access & pwrite & (pstrb[1:0] == 2'h3);
  // partial strobes on a 16-bit register would tear a field; refused
  wire bad = ~mapped | (pwrite & (sel_stat | (pstrb[1:0] != 2'h3)));

  // ==================================================================
  // storage
  logic [15:0] lane_q;
  logic [15:0] pat_q;
  logic [15:0] ser_q;
  logic [15:0] lane_d;
  logic [15:0] pat_d;
  logic [15:0] ser_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic trig_s;
  logic delay_busy;
  logic start_p;

  // host keeps the must-be bits; lane and pattern store what is written, serial keeps only AOCR_SER_MASK bits
  assign lane_d = (wr && sel_lane) ? pwdata[15:0] : lane_q;
  assign pat_d = (wr && sel_pat) ? pwdata[15:0] : pat_q;
  assign ser_d = (wr && sel_ser) ? (pwdata[15:0] & AOCR_SER_MASK) : ser_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      lane_q <= AOCR_LANE_RST;
      pat_q <= AOCR_PAT_RST;
      ser_q <= AOCR_SER_RST;
    end else if (ce) begin
      lane_q <= lane_d;
      pat_q <= pat_d;
      ser_q <= ser_d;
    end
  end

  // ==================================================================
  // read path
  wire [15:0] stat_word = {12'h000, delay_busy, cfg.rate_code_valid, converter_on, serial_lanes_on};

  // bits 4 and 2 of the lane register are write-only and read as zero
  assign rdata_d = !(psel && !penable && !pwrite) ? rdata_q :
                   sel_lane ? {16'h0000, lane_q & AOCR_LANE_RD_MASK} :
                   sel_pat ? {16'h0000, pat_q} :
                   sel_ser ? {16'h0000, ser_q} :
                   sel_stat ? {16'h0000, stat_word} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = access & bad;

  // ==================================================================
  // decoded settings
  // lane merge
  assign cfg.dual_lane_merge = lane_q[AOCR_LANE_MERGE_BIT];
  assign cfg.serial_output_off = lane_q[AOCR_SER_OFF_BIT];
  assign cfg.full_power_down = lane_q[AOCR_PDN_BIT];
  assign cfg.low_latency = pat_q[AOCR_LOWLAT_BIT];
  assign cfg.channel_pair_average = pat_q[AOCR_AVG_BIT];
  assign cfg.frame_line_random_sel = pat_q[AOCR_FRM_RND_BIT];
  assign cfg.global_random_sel = pat_q[AOCR_GBL_RND_BIT];
  assign cfg.data_line_pattern = aocr_pat_t'(pat_q[AOCR_DAT_PAT_LSB +: 3]);
  assign cfg.frame_line_pattern = aocr_pat_t'(pat_q[AOCR_FRM_PAT_LSB +: 3]);
  assign cfg.offset_fix_start_delay = {ser_q[AOCR_DLY_HI_LSB +: 2], pat_q[AOCR_DLY_LO_LSB +: 6]};
  assign cfg.serialization_factor = ser_q[AOCR_SER_RATE_LSB +: 3];
  assign cfg.rate_code_valid = (cfg.serialization_factor == AOCR_RATE_12X) |
                               (cfg.serialization_factor == AOCR_RATE_14X) |
                               (cfg.serialization_factor == AOCR_RATE_16X);
  // unused rate codes fall back to 12 bits
  assign cfg.bits_per_sample = (cfg.serialization_factor == AOCR_RATE_14X) ? AOCR_BITS_14 :
                               (cfg.serialization_factor == AOCR_RATE_16X) ? AOCR_BITS_16 : AOCR_BITS_12;
  assign cfg.digital_gain_on = ser_q[AOCR_GAIN_BIT];
  assign cfg.digital_offset_on = ser_q[AOCR_DOFS_BIT];

  // power-down also silences the serial lanes
  assign serial_lanes_on = ~cfg.serial_output_off & ~cfg.full_power_down;
  assign converter_on = ~cfg.full_power_down;

  // ==================================================================
  // trigger to offset-fix start
  aocr_sync u_trig_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .din(transmit_trigger_input),
    .dout(trig_s)
  );

  aocr_trig_delay #(
    .DLY_W(8)
  ) u_delay (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .sample_tick(sample_tick & converter_on),
    .trig(trig_s),
    .delay(cfg.offset_fix_start_delay),
    .start(start_p),
    .busy(delay_busy)
  );

  assign offset_fix_start = start_p;

endmodule

// ---- dv/aocr_regs_monitor.sv ----
// checker on the ports of the output config register bank
// assumes bind into aocr_regs and a single clock domain
`timescale 1ns/1ns
module aocr_mon
  import aocr_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // apb
  input wire logic [AOCR_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // settings
  input wire aocr_cfg_t cfg,
  input wire logic serial_lanes_on,
  input wire logic converter_on,
  input wire logic offset_fix_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wr_ok = psel & penable & pwrite & ce & (pstrb[1:0] == 2'h3);
  wire wr_lane = wr_ok & (paddr == 12'h004);
  wire wr_pat = wr_ok & (paddr == 12'h008);
  wire wr_ser = wr_ok & (paddr == 12'h00c);
  // ====================================================================
  // assertions
  a_lane_merge: assert property (wr_lane |=> cfg.dual_lane_merge == $past(pwdata[14]))
    else $error("merge bit not taken");
  a_lanes_off: assert property (serial_lanes_on == !(cfg.serial_output_off || cfg.full_power_down))
    else $error("serial lanes state wrong");
  a_power_down: assert property (wr_lane |=> converter_on == !$past(pwdata[0]))
    else $error("power down not taken");
  a_lat_avg: assert property (wr_pat |=>
    {cfg.low_latency, cfg.channel_pair_average, cfg.frame_line_random_sel} == $past(pwdata[12:10]))
    else $error("latency or average bits wrong");
  a_data_pat: assert property (wr_pat |=> cfg.data_line_pattern == $past(pwdata[9:7]))
    else $error("data pattern wrong");
  a_frame_pat: assert property (wr_pat |=> cfg.frame_line_pattern == $past(pwdata[15:13]))
    else $error("frame pattern wrong");
  a_delay_hi: assert property (wr_ok && paddr == 12'h00c |=>
    cfg.offset_fix_start_delay[7:6] == $past(pwdata[10:9]))
    else $error("delay high bits wrong");
  a_rate_bits: assert property (cfg.serialization_factor == AOCR_RATE_16X |->
    cfg.bits_per_sample == AOCR_BITS_16 && cfg.rate_code_valid)
    else $error("rate decode wrong");
  a_start_pulse: assert property (offset_fix_start && ce |=> !offset_fix_start)
    else $error("start not a single pulse");
  a_ser_off: assert property (wr_lane |=> cfg.serial_output_off == $past(pwdata[5]))
    else $error("serial off bit not taken");
  a_global_rnd: assert property (wr_pat |=> cfg.global_random_sel == $past(pwdata[6]))
    else $error("global random bit not taken");
  a_gain_on: assert property (wr_ser |=> cfg.digital_gain_on == $past(pwdata[12]))
    else $error("digital gain bit not taken");
endmodule
bind aocr_regs aocr_mon u_mon (.clk(clk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .cfg(cfg),
  .serial_lanes_on(serial_lanes_on), .converter_on(converter_on), .offset_fix_start(offset_fix_start));

// ---- dv/aocr_host.sv ----
// host model: apb master programming the config bank
// assumes the bench calls its tasks; signals change after rising edges
`timescale 1ns/1ns
module aocr_host
  import aocr_pkg::*;
(
  // apb master
  input wire logic clk,
  output logic [AOCR_ADDR_W-1:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end
  function automatic logic [15:0] lane_word(input logic [15:0] v);
    return (v & 16'h4021) | 16'h0014;
  endfunction
  // ====================================================================
  // one transfer, held until pready is seen
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // only the bench watchdog ends a wait for pready
    do @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the output config register bank
// assumes host model on apb; bench drives reset, ticks and trigger
`timescale 1ns/1ns
module tb
  import aocr_pkg::*;
;
  logic clk, rst, ce, tick, trig, psel, penable, pwrite, pready, pslverr, lanes_on, conv_on, ofs, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0] pstrb;
  logic [15:0] m [5];
  aocr_cfg_t cfg;
  int fails, tests_run, starts, base, i, c;
  int seed = 32'h9cf22389;
  aocr_host u_host (.clk(clk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  aocr_regs dut (.clk(clk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_tick(tick), .transmit_trigger_input(trig), .cfg(cfg), .serial_lanes_on(lanes_on),
    .converter_on(conv_on), .offset_fix_start(ofs));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (ofs === 1'b1) starts <= starts + 1;
  // ====================================================================
  // model and checks
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  function automatic logic [31:0] rexp(input int k);
    logic [2:0] r;
    r = m[3][15:13];
    if (k == 4) return {29'h0, r == 3'h0 || r == 3'h1 || r == 3'h4, ~m[1][0], ~m[1][0] & ~m[1][5]};
    return k == 1 ? m[1] & 16'h4021 : m[k];
  endfunction
  task rdchk(input int k);
    u_host.xfer(1'b0, 12'(k * 4), 32'h0, 4'hf, d, e);
    chk("read", rexp(k), d);
    chk("rerr", 32'h0, {31'h0, e});
  endtask
  task wr(input int k, input logic [15:0] v);
    if (k == 1) v = u_host.lane_word(v);
    if (k == 3) v = v & 16'hf700;
    m[k] = v;
    u_host.xfer(1'b1, 12'(k * 4), {~v, v}, 4'hf, d, e);
    chk("werr", 32'h0, {31'h0, e});
  endtask
  task cfgchk();
    logic [15:0] l, p, s;
    logic [4:0] b;
    logic [31:0] st;
    @(posedge clk);
    #1;
    l = m[1];
    p = m[2];
    s = m[3];
    st = rexp(4);
    b = s[15:13] == 3'h1 ? 5'h0e : s[15:13] == 3'h4 ? 5'h10 : 5'h0c;
    chk("cfg", {l[14], l[5], l[0], p[12:10], p[6], p[9:7], p[15:13], s[10:9], p[5:0], s[15:13], b,
      st[2], s[12], s[8]}, cfg);
    chk("pins", {~l[0] & ~l[5], ~l[0]}, {lanes_on, conv_on});
  endtask
  task do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    m = '{16'h0, 16'h0014, 16'h0, 16'h0, 16'h0};
    for (i = 1; i < 5; i++) rdchk(i);
    cfgchk();
  endtask
  task pulse();
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ====================================================================
  // tests
  initial begin
    fails = 0;
    tests_run = 0;
    {rst, ce, tick, trig} = 4'h8;
    ce = 1'b1;
    do_reset();
    $display("test reset done");
    repeat (40) begin
      i = 1 + {$random(seed)} % 3;
      wr(i, 16'($random(seed)));
      cfgchk();
      rdchk(i);
      rdchk(4);
    end
    do_reset();
    $display("test random done");
    for (c = 0; c < 8; c++) begin
      wr(2, 16'((c << 13) | (c << 7)));
      wr(3, 16'(c << 13));
      cfgchk();
    end
    $display("test codes done");
    // status write, unmapped, partial strobe, misaligned
    for (c = 0; c < 4; c++) begin
      u_host.xfer(1'b1, c == 0 ? 12'h010 : c == 1 ? 12'h020 : c == 2 ? 12'h008 : 12'h006,
        32'hffff, c == 2 ? 4'h1 : 4'hf, d, e);
      chk("refuse", 32'h1, {31'h0, e});
    end
    u_host.xfer(1'b0, 12'h040, 32'h0, 4'hf, d, e);
    chk("unmapped", {32'h0}, d);
    chk("unmapped_err", 32'h1, {31'h0, e});
    // a write while the clock enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    u_host.xfer(1'b1, 12'h008, 32'hffff, 4'hf, d, e);
    ce <= 1'b1;
    cfgchk();
    $display("test refuse done");
    wr(1, 16'h0);
    for (c = 0; c < 2; c++) begin
      wr(2, c ? 16'h0002 : 16'h0);
      wr(3, c ? 16'h0200 : 16'h0);
      base = starts;
      trig <= 1'b1;
      repeat (4) @(posedge clk);
      repeat (c ? 66 : 0) pulse();
      repeat (3) @(posedge clk);
      chk("early", 32'h0, starts - base);
      pulse();
      repeat (3) @(posedge clk);
      chk("start", 32'h1, starts - base);
      trig <= 1'b0;
      repeat (4) @(posedge clk);
    end
    $display("test trigger done");
    conclude();
  end
  initial begin
    #400000;
    fails++;
    conclude();
  end
endmodule
